// ===== rtl/gcrb_consts.svh
// Purpose: constants for the global configuration register bank
// Assumes: 8-bit index space, global registers at 0x00-0x2F
// Notes:   offsets, field positions, reset values
`ifndef GCRB_CONSTS_SVH
`define GCRB_CONSTS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define GCRB_IDX_SOFTRST   8'h02
`define GCRB_IDX_INDEXPTR  8'h03
`define GCRB_IDX_UNITSEL   8'h07
`define GCRB_IDX_CHIPID    8'h20
`define GCRB_IDX_REV       8'h21
`define GCRB_IDX_PWREN     8'h22
`define GCRB_IDX_PWRMGT    8'h23
`define GCRB_IDX_CLKCTL    8'h24
`define GCRB_IDX_ADDRLO    8'h26
`define GCRB_IDX_ADDRHI    8'h27
`define GCRB_IDX_LAST      8'h2F

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define GCRB_BIT_SOFTRST   0
`define GCRB_BIT_WAKEPWR   7
`define GCRB_BIT_SER2PWR   5
`define GCRB_BIT_PLLOFF    1
`define GCRB_BIT_ADDR16    6
`define GCRB_MASK_PWREN    8'hB9
`define GCRB_MASK_PWRMGT   8'h39
`define GCRB_MASK_CLKCTL   8'h4E
`define GCRB_MASK_STBY     8'hA0
`define GCRB_MASK_ADDRLO   8'hFE
`define GCRB_OSC_STOP      2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GCRB_RST_INDEXPTR  8'h03
`define GCRB_RST_UNITSEL   8'h00
`define GCRB_RST_PWR       8'h00
`define GCRB_RST_CLKCTL    8'h04
`define GCRB_RST_ADDRLO0   8'hF0
`define GCRB_RST_ADDRLO1   8'h70
`define GCRB_RST_ADDRHI    8'h03

`endif

// ===== rtl/gcrb_pkg.sv
// Purpose: types for the global configuration register bank
// Assumes: consts header carries the numbers
// Notes:   state struct lives in the main module
package gcrb_pkg;
    typedef logic [7:0] gcrb_byte_t;    // one register byte
    typedef logic [1:0] gcrb_sync_t;    // two-stage synchroniser
endpackage

// ===== rtl/gcrb_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: single clock, async active-low reset
// Notes:   first stage read only by second stage
module gcrb_sync
    import gcrb_pkg::*;
(
    input  wire logic clock_i,   // system clock
    input  wire logic rst_n_i,   // async reset, low
    input  wire logic ce_i,      // clock enable
    input  wire logic d_i,       // asynchronous level
    output logic      q_o        // synchronised level
);
    gcrb_sync_t stage_reg;       // stage 0 then stage 1

    // ------------------------------------------------------------
    // shift
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            stage_reg <= 2'h0;
        else if (ce_i)
            stage_reg <= {stage_reg[0], d_i};
    end

    assign q_o = stage_reg[1];
endmodule

// ===== rtl/gcrb_bank.sv
// Purpose: global configuration registers, index/data access
// Assumes: host strobes are synchronous single-cycle pulses
// Notes:   per-unit banks sit outside; activate strobe is routed
`include "gcrb_consts.svh"
module gcrb_bank
    import gcrb_pkg::*;
#(
    parameter gcrb_byte_t CHIP_ID  = 8'h5A, // arbitrary value
    parameter gcrb_byte_t REVISION = 8'h01, // arbitrary value
    parameter int         UNITS    = 9      // logical device count
)(
    input  wire logic        clock_i,       // system clock
    input  wire logic        rst_n_i,       // hard/main reset, low
    input  wire logic        stby_rst_n_i,  // standby power-on reset
    input  wire logic        ce_i,          // freezes state when low
    input  wire logic        cfg_mode_i,    // configuration mode entered
    input  wire logic        idx_wr_i,      // index port write strobe
    input  wire logic        dat_wr_i,      // data port write strobe
    input  wire logic        dat_rd_i,      // data port read strobe
    input  wire gcrb_byte_t  wdata_i,       // host write data
    input  wire logic        strap_i,       // address-select strap pin
    input  wire logic        power_good_i,  // internal power good
    input  wire logic        act_wr_i,      // activate write, from unit bank
    input  wire logic        act_val_i,     // activate value
    output gcrb_byte_t       rdata_o,       // data port read data
    output gcrb_byte_t       index_o,       // held index
    output gcrb_byte_t       unit_sel_o,    // current logical device
    output logic [UNITS-1:0] unit_act_o,    // activate per unit
    output logic             soft_rst_o,    // soft reset pulse
    output gcrb_byte_t       pwr_en_o,      // function power bits
    output gcrb_byte_t       pwr_mgt_o,     // power management bits
    output logic             pll_off_o,     // PLL switched off
    output logic             osc_run_o,     // oscillator running
    output logic             baud_clk_en_o, // baud generator clock on
    output logic             addr16_o,      // 16-bit qualification
    output logic [15:0]      cfg_base_o,    // live config port base
    output logic             trickle_run_o, // trickle clock runs
    output logic             trickle_src_o  // trickle source select
);
    import gcrb_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        gcrb_byte_t       index;     // held index
        gcrb_byte_t       unit_sel;  // logical device select
        logic [UNITS-1:0] act;       // activate bits
        gcrb_byte_t       pwr_mgt;   // power management
        gcrb_byte_t       clk_ctl;   // oscillator control
        gcrb_byte_t       addr_lo;   // staged base low byte
        gcrb_byte_t       addr_hi;   // base high byte
        gcrb_byte_t       base_lo;   // live base low byte
        gcrb_byte_t       rdata;     // read data
        logic             soft_rst;  // soft reset pulse
        logic [1:0]       strap_cnt; // strap reload edges, saturates
    } gcrb_state_t;

    gcrb_state_t state_reg;          // registered state
    gcrb_state_t state_next;         // next state
    gcrb_byte_t  pwr_reg;            // power enables, low part
    gcrb_byte_t  pwr_next;           // next power enables
    gcrb_byte_t  stby_reg;           // standby-domain power bits
    gcrb_byte_t  stby_next;          // next standby bits
    logic        strap_s;            // synchronised strap
    logic        pgood_s;            // synchronised power good
    logic        wr_ok;              // data write allowed
    logic        rd_ok;              // data read allowed

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    gcrb_sync u_sync_strap (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .d_i     (strap_i),
        .q_o     (strap_s)
    );

    gcrb_sync u_sync_pgood (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .d_i     (power_good_i),
        .q_o     (pgood_s)
    );

    // ------------------------------------------------------------
    // index decode helper, used for read and write
    // ------------------------------------------------------------
    function automatic logic hit(input gcrb_byte_t idx,
                                 input gcrb_byte_t want);
        hit = (idx == want);  // full 8-bit compare
    endfunction

    // data port only works in configuration mode
    assign wr_ok = dat_wr_i && cfg_mode_i;
    assign rd_ok = dat_rd_i && cfg_mode_i;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        pwr_next   = pwr_reg;
        stby_next  = stby_reg;
        // pulse lasts one cycle; hardware clears itself
        state_next.soft_rst = 1'b0;
        // strap reloaded for three edges after release: the
        // synchroniser output is only settled at the third
        if (state_reg.strap_cnt != 2'h3)
        begin
            state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
            state_next.addr_lo  = strap_s ? `GCRB_RST_ADDRLO1
                                          : `GCRB_RST_ADDRLO0;
            state_next.base_lo  = state_next.addr_lo;
        end
        // index held until next index write or soft reset
        if (idx_wr_i && cfg_mode_i)
            state_next.index = wdata_i;
        // soft reset: defined values only; others
        if (state_reg.soft_rst)
        begin
            state_next.index    = `GCRB_RST_INDEXPTR;
            state_next.unit_sel = `GCRB_RST_UNITSEL;
            state_next.act      = '0;
        end
        // activate applies to the selected unit only
        if (act_wr_i && cfg_mode_i && state_reg.unit_sel < UNITS)
            state_next.act[state_reg.unit_sel[3:0]] = act_val_i;
        if (wr_ok)
        begin
            if (hit(state_reg.index, `GCRB_IDX_SOFTRST))
                state_next.soft_rst = wdata_i[`GCRB_BIT_SOFTRST];
            else if (hit(state_reg.index, `GCRB_IDX_UNITSEL))
                state_next.unit_sel = wdata_i;
            else if (hit(state_reg.index, `GCRB_IDX_PWREN))
            begin
                // fixed bit positions, reserved dropped
                pwr_next  = wdata_i & `GCRB_MASK_PWREN
                                    & ~`GCRB_MASK_STBY;
                stby_next = wdata_i & `GCRB_MASK_STBY;
            end
            else if (hit(state_reg.index, `GCRB_IDX_PWRMGT))
                state_next.pwr_mgt = wdata_i & `GCRB_MASK_PWRMGT;
            else if (hit(state_reg.index, `GCRB_IDX_CLKCTL))
                state_next.clk_ctl = wdata_i & `GCRB_MASK_CLKCTL;
            else if (hit(state_reg.index, `GCRB_IDX_ADDRLO))
                state_next.addr_lo = wdata_i & `GCRB_MASK_ADDRLO;
            else if (hit(state_reg.index, `GCRB_IDX_ADDRHI))
            begin
                // high byte commits the move at once
                state_next.addr_hi = wdata_i;
                state_next.base_lo = state_reg.addr_lo;
            end
            // chip id, revision and reserved: write dropped
        end
        // read mux; unmapped indices return zero
        if (rd_ok)
        begin
            state_next.rdata = 8'h00;
            if (hit(state_reg.index, `GCRB_IDX_INDEXPTR))
                state_next.rdata = state_reg.index;
            else if (hit(state_reg.index, `GCRB_IDX_UNITSEL))
                state_next.rdata = state_reg.unit_sel;
            else if (hit(state_reg.index, `GCRB_IDX_CHIPID))
                state_next.rdata = CHIP_ID;
            else if (hit(state_reg.index, `GCRB_IDX_REV))
                state_next.rdata = REVISION;
            else if (hit(state_reg.index, `GCRB_IDX_PWREN))
                state_next.rdata = pwr_reg | stby_reg;
            else if (hit(state_reg.index, `GCRB_IDX_PWRMGT))
                state_next.rdata = state_reg.pwr_mgt;
            else if (hit(state_reg.index, `GCRB_IDX_CLKCTL))
                state_next.rdata = state_reg.clk_ctl;
            else if (hit(state_reg.index, `GCRB_IDX_ADDRLO))
                state_next.rdata = state_reg.addr_lo;
            else if (hit(state_reg.index, `GCRB_IDX_ADDRHI))
                state_next.rdata = state_reg.addr_hi;
        end
    end

    // ------------------------------------------------------------
    // main-reset domain registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // hard/main reset values
            state_reg          <= '0;
            state_reg.index    <= `GCRB_RST_INDEXPTR;
            state_reg.unit_sel <= `GCRB_RST_UNITSEL;
            state_reg.pwr_mgt  <= `GCRB_RST_PWR;
            state_reg.clk_ctl  <= `GCRB_RST_CLKCTL;
            state_reg.addr_lo  <= `GCRB_RST_ADDRLO0;
            state_reg.addr_hi  <= `GCRB_RST_ADDRHI;
            state_reg.base_lo  <= `GCRB_RST_ADDRLO0;
            pwr_reg            <= `GCRB_RST_PWR;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
            pwr_reg   <= pwr_next;
        end
    end

    // ------------------------------------------------------------
    // standby-domain bits: survive hard and main reset
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge stby_rst_n_i)
    begin
        if (!stby_rst_n_i)
            stby_reg <= `GCRB_RST_PWR;
        else if (ce_i)
            stby_reg <= stby_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata_o       = state_reg.rdata;
    assign index_o       = state_reg.index;
    assign unit_sel_o    = state_reg.unit_sel;
    assign unit_act_o    = state_reg.act;
    assign soft_rst_o    = state_reg.soft_rst;
    assign pwr_en_o      = pwr_reg | stby_reg;
    assign pwr_mgt_o     = state_reg.pwr_mgt;
    assign pll_off_o     = state_reg.clk_ctl[`GCRB_BIT_PLLOFF];
    // code 11 stops osc and baud clock; others run
    assign osc_run_o     = state_reg.clk_ctl[3:2] != `GCRB_OSC_STOP;
    assign baud_clk_en_o = state_reg.clk_ctl[3:2] != `GCRB_OSC_STOP;
    assign addr16_o      = state_reg.clk_ctl[`GCRB_BIT_ADDR16];
    // base only moves on the high-byte write or the strap reload after reset
    assign cfg_base_o    = {state_reg.addr_hi, state_reg.base_lo};
    // wake power bit gates trickle; source from power good
    assign trickle_run_o = stby_reg[`GCRB_BIT_WAKEPWR];
    assign trickle_src_o = stby_reg[`GCRB_BIT_WAKEPWR] & pgood_s;
endmodule

// ===== tb/gcrb_bank_properties.sv
// Purpose: port-level properties of the global register bank
// Assumes: one clock domain; strobes count only with ce and config mode
// Notes:   bound into every gcrb_bank instance
module gcrb_bank_properties
#(
    parameter logic [7:0] CHIP_ID  = 8'h5A, // arbitrary value
    parameter logic [7:0] REVISION = 8'h01, // arbitrary value
    parameter int         UNITS    = 9      // unit count
)(
    input wire logic        clock_i,    // clock
    input wire logic        rst_n_i,    // reset, low
    input wire logic        ce_i,       // run enable
    input wire logic        cfg_mode_i, // config mode
    input wire logic        idx_wr_i,   // index strobe
    input wire logic        dat_wr_i,   // data write strobe
    input wire logic        dat_rd_i,   // data read strobe
    input wire logic [7:0]  wdata_i,    // write data
    input wire logic [7:0]  rdata_o,    // read data
    input wire logic [7:0]  index_o,    // held index
    input wire logic        soft_rst_o, // soft reset pulse
    input wire logic [7:0]  pwr_mgt_o,  // power management
    input wire logic        pll_off_o,  // pll off
    input wire logic        osc_run_o,  // oscillator on
    input wire logic        addr16_o,   // 16-bit decode
    input wire logic [15:0] cfg_base_o  // live base
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic       tk;   // strobe taken
    logic [7:0] wd_q; // write data one cycle back
    logic       hi_q; // high base byte written last cycle
    logic [2:0] rel_q; // edges since reset release, saturating
    assign tk = ce_i && cfg_mode_i;
    // delayed copies keep $past off compound expressions
    always_ff @(posedge clock_i)
    begin
        wd_q <= wdata_i;
        hi_q <= tk && dat_wr_i && index_o == 8'h27;
    end
    // strap reload may still move the base in the first edges
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rel_q <= 3'h0;
        else if (ce_i && rel_q != 3'h4)
            rel_q <= rel_q + 3'h1;
    end
    property p_srst;
        tk && dat_wr_i && index_o == 8'h02 && wdata_i[0]
            |=> soft_rst_o ##1 !soft_rst_o;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset pulse");
    property p_idx_load;
        tk && idx_wr_i && !dat_wr_i && !soft_rst_o |=> index_o == wd_q;
    endproperty
    a_idx_load: assert property (p_idx_load) else $error("index");
    property p_idx_hold;
        !idx_wr_i && !dat_wr_i && !soft_rst_o |=> $stable(index_o);
    endproperty
    a_idx_hold: assert property (p_idx_hold) else $error("held");
    property p_mode_off;
        !cfg_mode_i |=> $stable(pwr_mgt_o);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("mode off");
    property p_rsvd;
        tk && dat_rd_i && index_o inside {8'h00, 8'h01, [8'h04:8'h06],
            [8'h08:8'h1F], 8'h25, [8'h28:8'h2F]} |=> rdata_o == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read");
    property p_id;
        tk && dat_rd_i && index_o == 8'h20 |=> rdata_o == CHIP_ID;
    endproperty
    a_id: assert property (p_id) else $error("id read");
    property p_rev;
        tk && dat_rd_i && index_o == 8'h21 |=> rdata_o == REVISION;
    endproperty
    a_rev: assert property (p_rev) else $error("revision read");
    property p_osc;
        tk && dat_wr_i && index_o == 8'h24 |=> pll_off_o == wd_q[1]
            && addr16_o == wd_q[6] && osc_run_o == (wd_q[3:2] != 2'h3);
    endproperty
    a_osc: assert property (p_osc) else $error("osc");
    property p_base;
        $changed(cfg_base_o) |-> hi_q || rel_q != 3'h4;
    endproperty
    a_base: assert property (p_base) else $error("base moved");
    c_srst: cover property (soft_rst_o);
    c_move: cover property (hi_q);
    c_id: cover property (tk && dat_rd_i && index_o == 8'h20);
endmodule

bind gcrb_bank gcrb_bank_properties #(
    .CHIP_ID(CHIP_ID), .REVISION(REVISION), .UNITS(UNITS)
) u_gcrb_bank_properties (
    .clock_i, .rst_n_i, .ce_i, .cfg_mode_i, .idx_wr_i, .dat_wr_i,
    .dat_rd_i, .wdata_i, .rdata_o, .index_o, .soft_rst_o, .pwr_mgt_o,
    .pll_off_o, .osc_run_o, .addr16_o, .cfg_base_o
);

// ===== tb/gcrb_host.sv
// Purpose: host model for the index and data ports
// Assumes: one-cycle strobes launched at the falling edge
// Notes:   released data lines show the inverted byte
module gcrb_host
(
    input  wire logic                 clock_i,  // system clock
    input  wire gcrb_pkg::gcrb_byte_t rdata_i,  // read data
    output logic                      idx_wr_o, // index strobe
    output logic                      dat_wr_o, // data write strobe
    output logic                      dat_rd_o, // data read strobe
    output gcrb_pkg::gcrb_byte_t      wdata_o   // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    import gcrb_pkg::*;
    initial
    begin
        {idx_wr_o, dat_wr_o, dat_rd_o} = 3'h0;
        wdata_o = 8'h00;
    end
    // one strobe cycle; old byte inverted so no stale value lingers
    task automatic pulse(input logic [2:0] s, input gcrb_byte_t v);
        @(negedge clock_i);
        {idx_wr_o, dat_wr_o, dat_rd_o} = s;
        wdata_o = v;
        @(negedge clock_i);
        {idx_wr_o, dat_wr_o, dat_rd_o} = 3'h0;
        wdata_o = ~v;
    endtask
    // index first, data after: the only legal order
    task automatic wr(input gcrb_byte_t i, input gcrb_byte_t v);
        pulse(3'h4, i);
        pulse(3'h2, v);
    endtask
    task automatic rd(input gcrb_byte_t i, output gcrb_byte_t v);
        pulse(3'h4, i);
        pulse(3'h1, ~i);
        @(negedge clock_i);
        v = rdata_i;
    endtask
endmodule

// ===== tb/gcrb_bank_tb.sv
// Purpose: self-checking bench for the global register bank
// Assumes: strap low, so the base comes up at 0x03F0
// Notes:   host model makes all index and data cycles
module gcrb_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gcrb_pkg::*;
    localparam gcrb_byte_t ID  = 8'hC3; // arbitrary value
    localparam gcrb_byte_t REV = 8'h07; // arbitrary value
    logic clock_i = 1'b0, rst_n_i = 1'b0, stby_rst_n_i = 1'b0;
    logic ce_i = 1'b1, cfg_mode_i = 1'b1, strap_i = 1'b0;
    logic power_good_i = 1'b1, act_wr_i = 1'b0, act_val_i = 1'b0;
    logic idx_wr_i, dat_wr_i, dat_rd_i, soft_rst_o, pll_off_o, osc_run_o;
    logic baud_clk_en_o, addr16_o, trickle_run_o, trickle_src_o;
    gcrb_byte_t wdata_i, rdata_o, index_o, unit_sel_o, pwr_en_o, pwr_mgt_o;
    gcrb_byte_t rv, v;
    logic [8:0]  unit_act_o;
    logic [15:0] cfg_base_o;
    int n_mismatch = 0, n_checks = 0;
    gcrb_byte_t ix [13] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h08,
        8'h1F, 8'h25, 8'h28, 8'h29, 8'h2A, 8'h20, 8'h21};
    always #5 clock_i = ~clock_i;
    gcrb_bank #(.CHIP_ID(ID), .REVISION(REV), .UNITS(9)) u_gcrb_bank (
        .clock_i, .rst_n_i, .stby_rst_n_i, .ce_i, .cfg_mode_i, .idx_wr_i,
        .dat_wr_i, .dat_rd_i, .wdata_i, .strap_i, .power_good_i, .act_wr_i,
        .act_val_i, .rdata_o, .index_o, .unit_sel_o, .unit_act_o,
        .soft_rst_o, .pwr_en_o, .pwr_mgt_o, .pll_off_o, .osc_run_o,
        .baud_clk_en_o, .addr16_o, .cfg_base_o, .trickle_run_o,
        .trickle_src_o);
    gcrb_host u_gcrb_host (.clock_i, .rdata_i(rdata_o), .idx_wr_o(idx_wr_i),
        .dat_wr_o(dat_wr_i), .dat_rd_o(dat_rd_i), .wdata_o(wdata_i));
    // ------------------------------------------------------------
    // compare and access tasks
    // ------------------------------------------------------------
    task automatic chk_val(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, g);
        chk_val(nm, {15'h0, e}, {15'h0, g});
    endtask
    task automatic wr(input gcrb_byte_t i, input gcrb_byte_t d);
        u_gcrb_host.wr(i, d);
    endtask
    task automatic rchk(input gcrb_byte_t i, input gcrb_byte_t e, string nm);
        u_gcrb_host.rd(i, rv);
        chk_val(nm, {8'h00, e}, {8'h00, rv});
    endtask
    task automatic act(input logic a);
        @(negedge clock_i);
        act_wr_i = 1'b1;
        act_val_i = a;
        @(negedge clock_i);
        act_wr_i = 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog: the whole run needs well under 10 us
    initial
    begin
        #50000;
        n_mismatch++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clock_i);
        rst_n_i = 1'b1;
        stby_rst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        rchk(8'h07, 8'h00, "unit");
        rchk(8'h24, 8'h04, "osc");
        rchk(8'h26, 8'hF0, "addr lo");
        rchk(8'h27, 8'h03, "addr hi");
        rchk(8'h03, 8'h03, "index");
        chk_val("base", 16'h03F0, cfg_base_o);
        $display("test reset done");
        foreach (ix[i])
        begin
            wr(ix[i], 8'hFF);
            rchk(ix[i], i == 11 ? ID : i == 12 ? REV : 8'h00,
                 "fixed");
        end
        wr(8'hA2, 8'hFF);
        rchk(8'h22, 8'h00, "alias");
        $display("test reserved done");
        wr(8'h22, 8'hFF);
        rchk(8'h22, 8'hB9, "power");
        chk_bit("trickle", 1'b1, trickle_run_o);
        repeat (3) @(negedge clock_i);
        chk_bit("trk src", 1'b1, trickle_src_o);
        power_good_i = 1'b0;
        repeat (3) @(negedge clock_i);
        chk_bit("trk src", 1'b0, trickle_src_o);
        wr(8'h23, 8'hFF);
        rchk(8'h23, 8'h39, "mgmt");
        cfg_mode_i = 1'b0;
        wr(8'h23, 8'h00);
        wr(8'h22, 8'h00);
        cfg_mode_i = 1'b1;
        rchk(8'h23, 8'h39, "mgmt");
        chk_val("power", 16'h00B9, {8'h00, pwr_en_o});
        $display("test power done");
        for (int c = 0; c < 4; c++)
        begin
            v = {1'b1, c[1], 2'h3, c[1:0], c[0], 1'b1};
            wr(8'h24, v);
            chk_bit("pll", c[0], pll_off_o);
            chk_bit("osc", c != 3, osc_run_o);
            chk_bit("baud", c != 3, baud_clk_en_o);
            chk_bit("addr16", c[1], addr16_o);
            rchk(8'h24, v & 8'h4E, "osc");
        end
        $display("test osc done");
        wr(8'h07, 8'h03);
        chk_val("unit sel", 16'h0003, {8'h00, unit_sel_o});
        act(1'b1);
        chk_val("act", 16'h0008, {7'h0, unit_act_o});
        wr(8'h07, 8'h05);
        act(1'b1);
        chk_val("act", 16'h0028, {7'h0, unit_act_o});
        act(1'b0);
        chk_val("act", 16'h0008, {7'h0, unit_act_o});
        wr(8'h02, 8'h01);
        chk_bit("srst", 1'b1, soft_rst_o);
        @(negedge clock_i);
        chk_bit("srst", 1'b0, soft_rst_o);
        rchk(8'h07, 8'h00, "unit");
        chk_val("act", 16'h0000, {7'h0, unit_act_o});
        rchk(8'h24, 8'h4E, "osc");
        chk_val("power", 16'h00B9, {8'h00, pwr_en_o});
        $display("test soft reset done");
        wr(8'h26, 8'h61);
        chk_val("base", 16'h03F0, cfg_base_o);
        rchk(8'h26, 8'h60, "addr lo");
        wr(8'h27, 8'h12);
        chk_val("base", 16'h1260, cfg_base_o);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        chk_val("power", 16'h00A0, {8'h00, pwr_en_o});
        chk_val("base", 16'h03F0, cfg_base_o);
        rchk(8'h24, 8'h04, "osc");
        rchk(8'h23, 8'h00, "mgmt");
        stby_rst_n_i = 1'b0;
        @(negedge clock_i);
        stby_rst_n_i = 1'b1;
        chk_val("power", 16'h0000, {8'h00, pwr_en_o});
        $display("test hard reset done");
        // strap high across a hard reset: base comes up at 0x0370
        strap_i = 1'b1;
        rst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        chk_val("base", 16'h0370, cfg_base_o);
        rchk(8'h26, 8'h70, "addr lo");
        $display("test strap done");
        wrap_up();
    end
endmodule
